// >>> bififo_defines.vh
`ifndef BIFIFO_DEFINES_VH
`define BIFIFO_DEFINES_VH

// ==========================================================
// data path and memory geometry
`define DATA_W        18
`define ADDR_W        9
`define CNT_W         10
`define DEPTH         10'h200
`define CNT_ZERO      10'h000
`define CNT_ONE       10'h001
`define PTR_ONE       9'h001
`define PTR_ZERO      9'h000
`define DATA_ZERO     18'h00000

// ==========================================================
// flag offset registers
`define OFF_W         9
`define OFF_RESET     9'h008
`define OFF_MSB       8
`define OFF_PAD       9'h000

// ==========================================================
// resource select codes
`define SEL_FIFO      3'h0
`define SEL_BYPASS    3'h1
`define SEL_TOP       2
`define OFF_AB_AE     2'h0
`define OFF_AB_AF     2'h1
`define OFF_BA_AE     2'h2
`define OFF_BA_AF     2'h3

// ==========================================================
// two-entry write buffer
`define BUF_W         2
`define BUF_EMPTY     2'h0
`define BUF_ONE       2'h1
`define BUF_TWO       2'h2

`endif

// >>> fifo_ram.v
`timescale 1ns/100ps
`include "bififo_defines.vh"

// ==========================================================
// simple dual port word store with registered read data
module fifo_ram (
  input  wire                 ref_clk,
  input  wire                 nrst,
  input  wire                 wr_en,
  input  wire [`ADDR_W-1:0]   wr_addr,
  input  wire [`DATA_W-1:0]   wr_data,
  input  wire                 rd_en,
  input  wire [`ADDR_W-1:0]   rd_addr,
  output reg  [`DATA_W-1:0]   rd_data
);

  reg [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

  // write port
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, data held until next read
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rd_data <= `DATA_ZERO;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // fifo_ram

// >>> bidir_fifo.v
`timescale 1ns/100ps
`include "bififo_defines.vh"

module bidir_fifo (
  input  wire                 ref_clk,
  input  wire                 nrst,
  input  wire                 port_a_clock,
  input  wire                 port_a_select_n,
  input  wire                 port_a_direction,
  input  wire                 port_a_xfer_en_n,
  input  wire                 port_a_drive_en_n,
  input  wire [2:0]           resource_select,
  input  wire [`DATA_W-1:0]   port_a_bus_in,
  output reg  [`DATA_W-1:0]   port_a_bus_out,
  output wire                 port_a_bus_oe_n,
  input  wire                 port_b_clock,
  input  wire                 port_b_direction,
  input  wire                 port_b_xfer_en_n,
  input  wire                 port_b_drive_en_n,
  input  wire [`DATA_W-1:0]   port_b_bus_in,
  output reg  [`DATA_W-1:0]   port_b_bus_out,
  output wire                 port_b_bus_oe_n,
  output reg                  bypass_indicator_n,
  output reg                  ab_full_n,
  output reg                  ab_empty_n,
  output reg                  ab_almost_empty_n,
  output reg                  ab_almost_full_n,
  output reg                  ba_full_n,
  output reg                  ba_empty_n,
  output reg                  ba_almost_empty_n,
  output reg                  ba_almost_full_n
);

  // ========================================================
  // port clock edge detection
  reg                 a_clk_q;
  reg                 b_clk_q;
  reg                 a_edge_d;
  reg                 b_edge_d;
  wire                a_edge;
  wire                b_edge;

  // port clocks arrive synchronous to ref_clk
  always @(posedge ref_clk) begin
    if (!nrst) begin
      a_clk_q  <= 1'b0;
      b_clk_q  <= 1'b0;
      a_edge_d <= 1'b0;
      b_edge_d <= 1'b0;
    end else begin
      a_clk_q  <= port_a_clock;
      b_clk_q  <= port_b_clock;
      a_edge_d <= a_edge;
      b_edge_d <= b_edge;
    end
  end

  assign a_edge = port_a_clock & ~a_clk_q;
  assign b_edge = port_b_clock & ~b_clk_q;

  // ========================================================
  // state declarations
  reg  [`OFF_W-1:0]   ab_ae_off;
  reg  [`OFF_W-1:0]   ab_af_off;
  reg  [`OFF_W-1:0]   ba_ae_off;
  reg  [`OFF_W-1:0]   ba_af_off;
  reg  [`OFF_W-1:0]   sel_off;
  reg  [`ADDR_W-1:0]  ab_wptr;
  reg  [`ADDR_W-1:0]  ab_rptr;
  reg  [`ADDR_W-1:0]  ba_wptr;
  reg  [`ADDR_W-1:0]  ba_rptr;
  reg  [`CNT_W-1:0]   ab_cnt;
  reg  [`CNT_W-1:0]   ba_cnt;
  reg  [`DATA_W-1:0]  buf0;
  reg  [`DATA_W-1:0]  buf1;
  reg  [`BUF_W-1:0]   buf_cnt;
  reg  [`DATA_W-1:0]  ab_byp_word;
  reg                 ab_byp_full;
  reg                 ab_byp_seen;
  reg                 ab_take;
  reg  [`DATA_W-1:0]  ba_byp_word;
  reg                 ba_byp_full;
  reg                 ba_byp_seen;
  reg                 ba_take;
  reg                 a_load_fifo;
  reg                 b_load_fifo;
  wire [`DATA_W-1:0]  ab_q;
  wire [`DATA_W-1:0]  ba_q;

  // ========================================================
  // request decode
  wire a_act     = a_edge & ~port_a_select_n & ~port_a_xfer_en_n;
  wire a_wr      = a_act & ~port_a_direction;
  wire a_rd      = a_act & port_a_direction;
  wire sel_fifo  = (resource_select == `SEL_FIFO);
  wire sel_byp   = (resource_select == `SEL_BYPASS);
  wire sel_reg   = resource_select[`SEL_TOP];
  wire byp_a     = ~port_a_select_n & sel_byp;
  wire byp_b     = ~bypass_indicator_n;
  wire b_act     = b_edge & ~port_b_xfer_en_n;
  wire b_wr      = b_act & ~port_b_direction;
  wire b_rd      = b_act & port_b_direction;
  wire byp_end   = b_edge & byp_b & ~byp_a;

  wire [`CNT_W-1:0] ab_total = ab_cnt + {{(`CNT_W-`BUF_W){1'b0}}, buf_cnt};

  // writes blocked while full, reads while empty
  wire a_wr_fifo = a_wr & sel_fifo & (buf_cnt != `BUF_TWO)
                   & (ab_total != `DEPTH);
  wire a_wr_byp  = a_wr & sel_byp & ~ab_byp_full;
  wire a_rd_fifo = a_rd & sel_fifo & (ba_cnt != `CNT_ZERO);
  wire a_rd_byp  = a_rd & sel_byp & ba_byp_seen;
  wire b_wr_fifo = b_wr & ~byp_b & (ba_cnt != `DEPTH);
  wire b_wr_byp  = b_wr & byp_b & ~ba_byp_full;
  wire b_rd_fifo = b_rd & ~byp_b & (ab_cnt != `CNT_ZERO);
  wire b_rd_byp  = b_rd & byp_b & ab_byp_seen;

  // ========================================================
  // two-entry buffer ahead of the A-to-B memory
  wire buf_pop   = (buf_cnt != `BUF_EMPTY) & (ab_cnt != `DEPTH);

  always @(posedge ref_clk) begin
    if (!nrst) begin
      buf0    <= `DATA_ZERO;
      buf1    <= `DATA_ZERO;
      buf_cnt <= `BUF_EMPTY;
    end else if (buf_pop && a_wr_fifo) begin
      if (buf_cnt == `BUF_ONE) begin
        buf0 <= port_a_bus_in;
      end else begin
        buf0 <= buf1;
        buf1 <= port_a_bus_in;
      end
    end else if (buf_pop) begin
      buf0    <= buf1;
      buf_cnt <= buf_cnt - `BUF_ONE;
    end else if (a_wr_fifo) begin
      if (buf_cnt == `BUF_EMPTY) begin
        buf0 <= port_a_bus_in;
      end else begin
        buf1 <= port_a_bus_in;
      end
      buf_cnt <= buf_cnt + `BUF_ONE;
    end
  end

  // ========================================================
  // memories
  fifo_ram ab_ram (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wr_en   (buf_pop),
    .wr_addr (ab_wptr),
    .wr_data (buf0),
    .rd_en   (b_rd_fifo),
    .rd_addr (ab_rptr),
    .rd_data (ab_q)
  );

  fifo_ram ba_ram (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wr_en   (b_wr_fifo),
    .wr_addr (ba_wptr),
    .wr_data (port_b_bus_in),
    .rd_en   (a_rd_fifo),
    .rd_addr (ba_rptr),
    .rd_data (ba_q)
  );

  // ========================================================
  // pointers and word counts
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ab_wptr <= `PTR_ZERO;
      ab_rptr <= `PTR_ZERO;
      ba_wptr <= `PTR_ZERO;
      ba_rptr <= `PTR_ZERO;
      ab_cnt  <= `CNT_ZERO;
      ba_cnt  <= `CNT_ZERO;
    end else begin
      if (buf_pop) begin
        ab_wptr <= ab_wptr + `PTR_ONE;
      end
      if (b_rd_fifo) begin
        ab_rptr <= ab_rptr + `PTR_ONE;
      end
      if (buf_pop && !b_rd_fifo) begin
        ab_cnt <= ab_cnt + `CNT_ONE;
      end else if (!buf_pop && b_rd_fifo) begin
        ab_cnt <= ab_cnt - `CNT_ONE;
      end
      if (b_wr_fifo) begin
        ba_wptr <= ba_wptr + `PTR_ONE;
      end
      if (a_rd_fifo) begin
        ba_rptr <= ba_rptr + `PTR_ONE;
      end
      if (b_wr_fifo && !a_rd_fifo) begin
        ba_cnt <= ba_cnt + `CNT_ONE;
      end else if (!b_wr_fifo && a_rd_fifo) begin
        ba_cnt <= ba_cnt - `CNT_ONE;
      end
    end
  end

  // ========================================================
  // flag offset registers
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ab_ae_off <= `OFF_RESET;
      ab_af_off <= `OFF_RESET;
      ba_ae_off <= `OFF_RESET;
      ba_af_off <= `OFF_RESET;
    end else if (a_wr && sel_reg) begin
      case (resource_select[1:0])
        `OFF_AB_AE: ab_ae_off <= port_a_bus_in[`OFF_W-1:0];
        `OFF_AB_AF: ab_af_off <= port_a_bus_in[`OFF_W-1:0];
        `OFF_BA_AE: ba_ae_off <= port_a_bus_in[`OFF_W-1:0];
        default:    ba_af_off <= port_a_bus_in[`OFF_W-1:0];
      endcase
    end
  end

  // selected offset for readback
  always @* begin
    case (resource_select[1:0])
      `OFF_AB_AE: sel_off = ab_ae_off;
      `OFF_AB_AF: sel_off = ab_af_off;
      `OFF_BA_AE: sel_off = ba_ae_off;
      default:    sel_off = ba_af_off;
    endcase
  end

  // ========================================================
  // bypass indicator, follows port A on port B edges
  always @(posedge ref_clk) begin
    if (!nrst) begin
      bypass_indicator_n <= 1'b1;
    end else if (b_edge) begin
      bypass_indicator_n <= ~byp_a;
    end
  end

  // ========================================================
  // A-to-B bypass word handshake
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ab_byp_word <= `DATA_ZERO;
      ab_byp_full <= 1'b0;
      ab_byp_seen <= 1'b0;
      ab_take     <= 1'b0;
    end else if (byp_end) begin
      ab_byp_full <= 1'b0;
      ab_byp_seen <= 1'b0;
      ab_take     <= 1'b0;
    end else begin
      if (a_wr_byp) begin
        ab_byp_word <= port_a_bus_in;
        ab_byp_full <= 1'b1;
      end else if (a_edge && ab_take) begin
        ab_byp_full <= 1'b0;
      end
      if (b_rd_byp) begin
        ab_byp_seen <= 1'b0;
      end else if (b_edge && ab_byp_full && !ab_take) begin
        ab_byp_seen <= 1'b1;
      end
      if (b_rd_byp) begin
        ab_take <= 1'b1;
      end else if (a_edge) begin
        ab_take <= 1'b0;
      end
    end
  end

  // ========================================================
  // B-to-A bypass word handshake, independent of the other way
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ba_byp_word <= `DATA_ZERO;
      ba_byp_full <= 1'b0;
      ba_byp_seen <= 1'b0;
      ba_take     <= 1'b0;
    end else if (byp_end) begin
      ba_byp_full <= 1'b0;
      ba_byp_seen <= 1'b0;
      ba_take     <= 1'b0;
    end else begin
      if (b_wr_byp) begin
        ba_byp_word <= port_b_bus_in;
        ba_byp_full <= 1'b1;
      end else if (b_edge && ba_take) begin
        ba_byp_full <= 1'b0;
      end
      if (a_rd_byp) begin
        ba_byp_seen <= 1'b0;
      end else if (a_edge && ba_byp_full && !ba_take) begin
        ba_byp_seen <= 1'b1;
      end
      if (a_rd_byp) begin
        ba_take <= 1'b1;
      end else if (b_edge) begin
        ba_take <= 1'b0;
      end
    end
  end

  // ========================================================
  // port A output register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      port_a_bus_out <= `DATA_ZERO;
      a_load_fifo    <= 1'b0;
    end else begin
      a_load_fifo <= a_rd_fifo;
      if (a_load_fifo) begin
        port_a_bus_out <= ba_q;
      end else if (a_rd && sel_byp) begin
        port_a_bus_out <= ba_byp_word;
      end else if (a_rd && sel_reg) begin
        port_a_bus_out <= {`OFF_PAD, sel_off};
      end
    end
  end

  // ========================================================
  // port B output register
  always @(posedge ref_clk) begin
    if (!nrst) begin
      port_b_bus_out <= `DATA_ZERO;
      b_load_fifo    <= 1'b0;
    end else begin
      b_load_fifo <= b_rd_fifo;
      if (b_load_fifo) begin
        port_b_bus_out <= ab_q;
      end else if (b_rd_byp) begin
        port_b_bus_out <= ab_byp_word;
      end
    end
  end

  // bus drive, enables low while driving
  assign port_a_bus_oe_n = port_a_select_n | ~port_a_direction
                           | port_a_drive_en_n;
  assign port_b_bus_oe_n = ~port_b_direction | port_b_drive_en_n;

  // ========================================================
  // threshold comparisons
  wire [`CNT_W-1:0] ab_ae_lim = {1'b0, ab_ae_off};
  wire [`CNT_W-1:0] ab_af_lim = `DEPTH - {1'b0, ab_af_off};
  wire [`CNT_W-1:0] ba_ae_lim = {1'b0, ba_ae_off};
  wire [`CNT_W-1:0] ba_af_lim = `DEPTH - {1'b0, ba_af_off};

  // ========================================================
  // flags watched by port A, updated after port A edges
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ab_full_n         <= 1'b1;
      ab_almost_full_n  <= 1'b1;
      ba_empty_n        <= 1'b0;
      ba_almost_empty_n <= 1'b0;
    end else if (a_edge_d) begin
      ab_full_n         <= byp_a ? ~ab_byp_full
                                 : (ab_total != `DEPTH);
      ab_almost_full_n  <= (ab_total < ab_af_lim);
      ba_empty_n        <= byp_a ? ba_byp_seen
                                 : (ba_cnt != `CNT_ZERO);
      ba_almost_empty_n <= (ba_cnt > ba_ae_lim);
    end
  end

  // ========================================================
  // flags watched by port B, updated after port B edges
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ab_empty_n        <= 1'b0;
      ab_almost_empty_n <= 1'b0;
      ba_full_n         <= 1'b1;
      ba_almost_full_n  <= 1'b1;
    end else if (b_edge_d) begin
      ab_empty_n        <= byp_b ? ab_byp_seen
                                 : (ab_cnt != `CNT_ZERO);
      ab_almost_empty_n <= (ab_cnt > ab_ae_lim);
      ba_full_n         <= byp_b ? ~ba_byp_full
                                 : (ba_cnt != `DEPTH);
      ba_almost_full_n  <= (ba_cnt < ba_af_lim);
    end
  end

endmodule // bidir_fifo

// >>> bidir_fifo_chk.sv
`timescale 1ns/100ps
`include "bififo_defines.vh"

// ==========================================================
// port and flag timing checker
module bidir_fifo_chk (
  input wire               ref_clk,
  input wire               nrst,
  input wire               port_a_clock,
  input wire               port_a_select_n,
  input wire               port_a_direction,
  input wire               port_a_xfer_en_n,
  input wire               port_a_drive_en_n,
  input wire [2:0]         resource_select,
  input wire [`DATA_W-1:0] port_a_bus_out,
  input wire               port_a_bus_oe_n,
  input wire               port_b_clock,
  input wire               port_b_direction,
  input wire               port_b_drive_en_n,
  input wire               port_b_bus_oe_n,
  input wire               bypass_indicator_n,
  input wire               ab_full_n,
  input wire               ab_empty_n,
  input wire               ba_full_n,
  input wire               ba_empty_n
);
  reg  a_prev, b_prev, a_rd_d1, a_rd_d2, a_ev_d1, a_ev_d2, b_ev_d1, b_ev_d2;
  wire a_edge = port_a_clock & ~a_prev;
  wire b_edge = port_b_clock & ~b_prev;
  wire a_take = a_edge & ~port_a_select_n & ~port_a_xfer_en_n;

  // port clock history and edge delay line
  always @(posedge ref_clk) begin
    if (!nrst) begin
      {a_prev, b_prev, a_rd_d1, a_rd_d2, a_ev_d1, a_ev_d2, b_ev_d1, b_ev_d2} <= 8'h00;
    end else begin
      {a_prev, b_prev} <= {port_a_clock, port_b_clock};
      {a_rd_d1, a_rd_d2} <= {a_take & port_a_direction, a_rd_d1};
      {a_ev_d1, a_ev_d2} <= {a_edge, a_ev_d1};
      {b_ev_d1, b_ev_d2} <= {b_edge, b_ev_d1};
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_bypass_wr;
    a_take && !port_a_direction && resource_select == `SEL_BYPASS && ab_full_n;
  endsequence
  sequence s_empty_rd;
    a_take && port_a_direction && resource_select == `SEL_FIFO && !ba_empty_n;
  endsequence
  property p_reset;
    $rose(nrst) |-> !ab_empty_n && !ba_empty_n && ab_full_n && ba_full_n && bypass_indicator_n;
  endproperty
  property p_oe_a;
    port_a_bus_oe_n == !(!port_a_select_n && port_a_direction && !port_a_drive_en_n);
  endproperty
  property p_oe_b;
    port_b_bus_oe_n == (!port_b_direction || port_b_drive_en_n);
  endproperty
  property p_desel;
    b_edge && port_a_select_n |-> ##[1:2] bypass_indicator_n;
  endproperty
  property p_bypass_on;
    b_edge && !port_a_select_n && resource_select == `SEL_BYPASS |-> ##[1:2] !bypass_indicator_n;
  endproperty
  property p_a_hold;
    $changed(port_a_bus_out) |-> a_rd_d1 || a_rd_d2;
  endproperty
  property p_bypass_full;
    s_bypass_wr |-> ##[1:2] !ab_full_n;
  endproperty
  property p_empty_rd;
    s_empty_rd |=> $stable(port_a_bus_out) [*2];
  endproperty
  property p_full_sync;
    $changed(ab_full_n) |-> a_ev_d1 || a_ev_d2;
  endproperty
  property p_empty_sync;
    $changed(ab_empty_n) |-> b_ev_d1 || b_ev_d2;
  endproperty

  a_reset: assert property (p_reset) else $error("flags wrong after reset");
  a_oe_a: assert property (p_oe_a) else $error("port a drive wrong");
  a_oe_b: assert property (p_oe_b) else $error("port b drive wrong");
  a_desel: assert property (p_desel) else $error("indicator low while deselected");
  a_bypass_on: assert property (p_bypass_on) else $error("indicator not low");
  a_a_hold: assert property (p_a_hold) else $error("port a output moved");
  a_bypass_full: assert property (p_bypass_full) else $error("full not dropped");
  a_empty_rd: assert property (p_empty_rd) else $error("read from empty");
  a_full_sync: assert property (p_full_sync) else $error("full off port a edge");
  a_empty_sync: assert property (p_empty_sync) else $error("empty off port b edge");
endmodule // bidir_fifo_chk

bind bidir_fifo bidir_fifo_chk chk (.*);

// >>> port_b_host.sv
`timescale 1ns/100ps
`include "bififo_defines.vh"

// ==========================================================
// second processor on port B, clock still between operations
module port_b_host (
  input  wire               ref_clk,
  input  wire [`DATA_W-1:0] port_b_bus_out,
  output reg                port_b_clock,
  output reg                port_b_direction,
  output reg                port_b_xfer_en_n,
  output reg                port_b_drive_en_n,
  output reg  [`DATA_W-1:0] port_b_bus_in
);
  reg [`DATA_W-1:0] last;

  // idle: no transfer, bus released
  initial begin
    port_b_clock = 1'h0;
    port_b_direction = 1'h1;
    port_b_xfer_en_n = 1'h1;
    port_b_drive_en_n = 1'h1;
    last = `DATA_ZERO;
    port_b_bus_in = ~last;
  end

  // one cycle: clock high one ref_clk, low for two more
  task b_op(input dir, input en_n, input [`DATA_W-1:0] d, output [`DATA_W-1:0] q);
    begin
      @(posedge ref_clk);
      #1;
      port_b_direction = dir;
      port_b_xfer_en_n = en_n;
      port_b_drive_en_n = ~dir;
      if (!dir) begin
        last = d;
      end
      port_b_bus_in = dir ? ~last : d; // write word, or released bus
      port_b_clock = 1'h1;
      repeat (3) begin
        @(posedge ref_clk);
        #1;
        port_b_clock = 1'h0;
      end
      port_b_xfer_en_n = 1'h1;
      port_b_bus_in = ~last; // released bus shows inverse of last word
      q = port_b_bus_out;
    end
  endtask
endmodule // port_b_host

// >>> bidir_fifo_bench.sv
`timescale 1ns/100ps
`include "bififo_defines.vh"

`define CHK(what, exp, got) \
  begin \
    compares = compares + 1; \
    if ((got) !== (exp)) begin \
      errors = errors + 1; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end

// ==========================================================
// bench for the two-way word buffer
module bidir_fifo_bench;
  reg                ref_clk, nrst, port_a_clock, port_a_select_n, port_a_direction;
  reg                port_a_xfer_en_n, port_a_drive_en_n;
  reg  [2:0]         resource_select;
  reg  [`DATA_W-1:0] port_a_bus_in, bq;
  wire [`DATA_W-1:0] port_a_bus_out, port_b_bus_in, port_b_bus_out;
  wire               port_a_bus_oe_n, port_b_clock, port_b_direction, port_b_xfer_en_n;
  wire               port_b_drive_en_n, port_b_bus_oe_n, bypass_indicator_n;
  wire               ab_full_n, ab_empty_n, ab_almost_empty_n, ab_almost_full_n;
  wire               ba_full_n, ba_empty_n, ba_almost_empty_n, ba_almost_full_n;
  integer            errors, compares, cycles;

  bidir_fifo dut (.*);
  port_b_host pb (.*);

  // reference clock, 25 ns
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test;
    end
  end

  // verdict and end of run
  task finish_test;
    begin
      if (errors == 0 && compares > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  // one port A cycle; select stays as left
  task a_op(input dir, input en_n, input [2:0] sel, input [`DATA_W-1:0] d);
    begin
      @(posedge ref_clk);
      #1;
      port_a_direction = dir;
      port_a_xfer_en_n = en_n;
      resource_select = sel;
      port_a_bus_in = dir ? ~port_a_bus_in : d;
      port_a_clock = 1'h1;
      repeat (3) begin
        @(posedge ref_clk);
        #1;
        port_a_clock = 1'h0;
      end
      port_a_xfer_en_n = 1'h1;
    end
  endtask

  // offset registers: reset value, write and read back
  task t_offsets;
    reg [3:0] i;
    reg [8:0] off;
    begin
      port_a_select_n = 1'h0;
      for (i = 4; i < 8; i = i + 1) begin
        a_op(1'h1, 1'h0, i[2:0], `DATA_ZERO);
        `CHK("offset reset", {`OFF_PAD, `OFF_RESET}, port_a_bus_out)
        off = i - 3;
        a_op(1'h0, 1'h0, i[2:0], {9'h1FF, off});
      end
      for (i = 4; i < 8; i = i + 1) begin
        off = i - 3;
        a_op(1'h1, 1'h0, i[2:0], `DATA_ZERO);
        `CHK("offset readback", {`OFF_PAD, off}, port_a_bus_out)
      end
    end
  endtask

  // A-to-B words through memory, almost-empty offset 1
  task t_ab_fifo;
    reg [17:0] k;
    begin
      for (k = 1; k < 4; k = k + 1) begin
        a_op(1'h0, 1'h0, `SEL_FIFO, 18'h00100 + k);
        pb.b_op(1'h1, 1'h1, `DATA_ZERO, bq);
        `CHK("ab_empty_n", 1'h1, ab_empty_n)
        `CHK("ab_almost_empty_n", k > 1, ab_almost_empty_n)
      end
      for (k = 1; k < 4; k = k + 1) begin
        pb.b_op(1'h1, 1'h0, `DATA_ZERO, bq);
        `CHK("b word", 18'h00100 + k, bq)
      end
      `CHK("ab_empty_n", 1'h0, ab_empty_n)
    end
  endtask

  // fill with port B stalled, one refused write, then drain
  task t_fill;
    reg [17:0] k;
    begin
      for (k = 1; k <= 18'h00200; k = k + 1) begin
        a_op(1'h0, 1'h0, `SEL_FIFO, 18'h15555 ^ k);
        if (k >= 18'h001FD) begin
          `CHK("ab_almost_full_n", k < 18'h001FE, ab_almost_full_n)
          `CHK("ab_full_n", k < 18'h00200, ab_full_n)
        end
      end
      a_op(1'h0, 1'h0, `SEL_FIFO, 18'h3FFFF);
      for (k = 1; k <= 18'h00200; k = k + 1) begin
        pb.b_op(1'h1, 1'h0, `DATA_ZERO, bq);
        `CHK("drained word", 18'h15555 ^ k, bq)
      end
      `CHK("ab_empty_n", 1'h0, ab_empty_n)
    end
  endtask

  // B-to-A words: disabled, deselected, in order, past empty
  task t_ba_fifo;
    reg [17:0] keep;
    begin
      pb.b_op(1'h0, 1'h0, 18'h0AB01, bq);
      pb.b_op(1'h0, 1'h0, 18'h0AB02, bq);
      keep = port_a_bus_out;
      a_op(1'h1, 1'h1, `SEL_FIFO, `DATA_ZERO);
      `CHK("held output", keep, port_a_bus_out)
      `CHK("ba_empty_n", 1'h1, ba_empty_n)
      `CHK("ba_almost_empty_n", 1'h0, ba_almost_empty_n)
      `CHK("ba_almost_full_n", 1'h1, ba_almost_full_n)
      port_a_select_n = 1'h1;
      a_op(1'h1, 1'h0, `SEL_FIFO, `DATA_ZERO);
      `CHK("deselected read", keep, port_a_bus_out)
      port_a_select_n = 1'h0;
      a_op(1'h1, 1'h0, `SEL_FIFO, `DATA_ZERO);
      `CHK("first word", 18'h0AB01, port_a_bus_out)
      a_op(1'h1, 1'h0, `SEL_FIFO, `DATA_ZERO);
      `CHK("second word", 18'h0AB02, port_a_bus_out)
      a_op(1'h1, 1'h0, `SEL_FIFO, `DATA_ZERO);
      `CHK("read past empty", 18'h0AB02, port_a_bus_out)
    end
  endtask

  // both bypass paths, then leave and deselect
  task t_bypass;
    begin
      a_op(1'h0, 1'h0, `SEL_BYPASS, 18'h2A5A5);
      `CHK("ab_full_n", 1'h0, ab_full_n)
      a_op(1'h0, 1'h0, `SEL_BYPASS, 18'h15A5A);
      pb.b_op(1'h1, 1'h1, `DATA_ZERO, bq);
      `CHK("bypass_indicator_n", 1'h0, bypass_indicator_n)
      pb.b_op(1'h0, 1'h0, 18'h0C3C3, bq);
      `CHK("ab_empty_n", 1'h1, ab_empty_n)
      `CHK("ba_full_n", 1'h0, ba_full_n)
      a_op(1'h1, 1'h1, `SEL_BYPASS, `DATA_ZERO);
      `CHK("ba_empty_n", 1'h1, ba_empty_n)
      a_op(1'h1, 1'h0, `SEL_BYPASS, `DATA_ZERO);
      `CHK("a bypass word", 18'h0C3C3, port_a_bus_out)
      pb.b_op(1'h1, 1'h0, `DATA_ZERO, bq);
      `CHK("b bypass word", 18'h2A5A5, bq)
      `CHK("ab_empty_n", 1'h0, ab_empty_n)
      `CHK("ba_full_n", 1'h1, ba_full_n)
      `CHK("ba_empty_n", 1'h0, ba_empty_n)
      `CHK("ab_full_n", 1'h0, ab_full_n)
      a_op(1'h1, 1'h1, `SEL_BYPASS, `DATA_ZERO);
      `CHK("ab_full_n", 1'h1, ab_full_n)
      a_op(1'h1, 1'h1, `SEL_FIFO, `DATA_ZERO);
      `CHK("ab_full_n", 1'h1, ab_full_n)
      pb.b_op(1'h1, 1'h1, `DATA_ZERO, bq);
      `CHK("bypass_indicator_n", 1'h1, bypass_indicator_n)
      `CHK("ab_empty_n", 1'h0, ab_empty_n)
      a_op(1'h1, 1'h1, `SEL_BYPASS, `DATA_ZERO);
      pb.b_op(1'h1, 1'h1, `DATA_ZERO, bq);
      port_a_select_n = 1'h1;
      pb.b_op(1'h1, 1'h1, `DATA_ZERO, bq);
      `CHK("bypass_indicator_n", 1'h1, bypass_indicator_n)
    end
  endtask

  // main sequence
  initial begin
    {errors, compares, cycles} = {32'h0, 32'h0, 32'h0};
    {nrst, port_a_clock, port_a_direction, port_a_drive_en_n} = 4'h2;
    {port_a_select_n, port_a_xfer_en_n} = 2'h3;
    resource_select = `SEL_FIFO;
    port_a_bus_in = `DATA_ZERO;
    repeat (6) @(posedge ref_clk);
    #1;
    nrst = 1'h1;
    t_offsets;
    t_ab_fifo;
    t_fill;
    t_ba_fifo;
    t_bypass;
    finish_test;
  end
endmodule // bidir_fifo_bench
